// *** design/rcsc_top.sv ***
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module rcsc_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Reset pin and sources
  input  wire logic        reset_pin_n,
  input  wire logic        watchdog_reset_req,
  // AXI4-Lite write
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // System outputs
  output logic             sys_reset_n,
  output logic             clk_sel_low,
  output logic             hf_osc_en,
  output logic             lf_osc_en,
  output logic [15:0]      pc_load,
  output logic             irq
);
  localparam int IRQ_W_L = rcsc_pkg::IRQ_W;
  logic [7:0]  sysctl2;
  logic [7:0]  wdctl1;
  logic [7:0]  tmr_ctl;
  logic [15:0] tmr_reload;
  logic [15:0] tmr_cnt;
  logic [15:0] fetch_addr;
  logic        irq_master;
  logic [7:0]  irq_enables;
  logic [3:0]  prescale;
  logic [IRQ_W_L-1:0] irq_st;
  logic [IRQ_W_L-1:0] irq_mask;
  logic [IRQ_W_L-1:0] ev;
  logic        pin_s1, pin_s2;
  logic [4:0]  pin_low_cnt;
  logic        ext_rst;
  logic [4:0]  malf_cnt;
  logic        malf_rst;
  logic        clk_req_low;
  logic        sel_low;
  logic [2:0]  sync_cnt;
  logic        trap_hit;
  logic        sysclk_fault;
  logic        tmr_tc;
  logic        aw_h, w_h;
  logic [7:0]  aw_a;
  logic [31:0] w_d;
  logic        wr_go;
  logic [7:0]  wr_val;
  rcsc_pkg::rcsc_mode_t mode;
  rcsc_pkg::rcsc_fetch_t fetch;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Synchronize reset pin before combining
  always_ff @(posedge aclk) begin
    pin_s1 <= reset_pin_n;
    pin_s2 <= pin_s1;
  end

  // Pin must stay low long enough to count as a reset
  always_ff @(posedge aclk) begin
    if (!aresetn || pin_s2) begin
      pin_low_cnt <= 5'h00;
      ext_rst     <= !aresetn;
    end else if (pin_low_cnt >= rcsc_pkg::PIN_CYC - 5'h01) begin
      ext_rst <= 1'b1;
    end else begin
      pin_low_cnt <= pin_low_cnt + 5'h01;
    end
  end

  assign wr_go  = aw_h && w_h && !s_bvalid;
  assign wr_val = w_d[7:0];
  assign fetch  = '{valid: fetch_addr != 16'h0000, addr: fetch_addr};
  assign trap_hit = fetch.valid && (in_range(fetch.addr, 16'h0001, rcsc_pkg::SFR_END) ||
                    in_range(fetch.addr, rcsc_pkg::DBR_START, rcsc_pkg::DBR_END) ||
                    (wdctl1[rcsc_pkg::BIT_TRAP_RAM_AREA_SELECT] &&
                     in_range(fetch.addr, rcsc_pkg::SFR_END + 16'h0001, rcsc_pkg::RAM_END)));
  // System-clock check on a write to the control register
  assign sysclk_fault = wr_go && aw_a == rcsc_pkg::ADDR_SYSCTL2 &&
                        ((sysctl2[rcsc_pkg::BIT_XEN] && sysctl2[rcsc_pkg::BIT_XTEN] &&
                          !wr_val[rcsc_pkg::BIT_XEN] && !wr_val[rcsc_pkg::BIT_XTEN]) ||
                         (!wr_val[rcsc_pkg::BIT_XEN] && !sysctl2[rcsc_pkg::BIT_SYSCK]) ||
                         (!wr_val[rcsc_pkg::BIT_XTEN] && sysctl2[rcsc_pkg::BIT_SYSCK])) ||
                        (wr_go && aw_a == rcsc_pkg::ADDR_SYSCTL2 &&
                         !wr_val[rcsc_pkg::BIT_XEN] && !wr_val[rcsc_pkg::BIT_XTEN]);

  // Malfunction reset stretcher, bounded length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      malf_cnt <= 5'h00;
      malf_rst <= 1'b0;
    end else if (watchdog_reset_req || sysclk_fault ||
                 (trap_hit && wdctl1[rcsc_pkg::BIT_ATOUT])) begin
      malf_cnt <= rcsc_pkg::MALF_CYC - 5'h01;
      malf_rst <= 1'b1;
    end else if (malf_cnt != 5'h00) begin
      malf_cnt <= malf_cnt - 5'h01;
    end else begin
      malf_rst <= 1'b0;
    end
  end

  // Combined internal reset
  always_ff @(posedge aclk) begin
    sys_reset_n <= !(ext_rst || malf_rst);
    pc_load     <= rcsc_pkg::RESET_VECTOR;
  end

  wire int_rst = ext_rst || malf_rst;

  // AXI write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      w_h  <= 1'b0;
      aw_a <= 8'h00;
      w_d  <= 32'h0000_0000;
      s_bvalid <= 1'b0;
      s_bresp  <= 2'b00;
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_h <= 1'b1;
        aw_a <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_h <= 1'b1;
        w_d <= s_wstrb[0] ? s_wdata : 32'h0000_0000;
        s_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_h <= 1'b0;
        w_h  <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (aw_a <= rcsc_pkg::ADDR_IRQ_EN && aw_a[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // Control register and clock mode
  // Any reset restores high clock, so a clock fault cannot deadlock
  always_ff @(posedge aclk) begin
    if (!aresetn || int_rst) begin
      sysctl2     <= rcsc_pkg::SYSCTL2_RESET;
      clk_req_low <= 1'b0;
    end else if (wr_go && aw_a == rcsc_pkg::ADDR_SYSCTL2) begin
      sysctl2     <= wr_val;
      clk_req_low <= wr_val[rcsc_pkg::BIT_SYSCK];
    end
  end

  // Hold low clock until the two clocks are aligned
  always_ff @(posedge aclk) begin
    if (!aresetn || int_rst) begin
      sel_low  <= 1'b0;
      sync_cnt <= 3'h0;
    end else if (clk_req_low) begin
      sel_low  <= 1'b1;
      sync_cnt <= rcsc_pkg::SYNC_CYC;
    end else if (sel_low && sync_cnt != 3'h0) begin
      sync_cnt <= sync_cnt - 3'h1;
    end else begin
      sel_low <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    clk_sel_low <= sel_low;
    hf_osc_en   <= sysctl2[rcsc_pkg::BIT_XEN] || int_rst;
    lf_osc_en   <= sysctl2[rcsc_pkg::BIT_XTEN];
  end

  always_comb begin
    case ({sel_low, sysctl2[rcsc_pkg::BIT_XEN], sysctl2[rcsc_pkg::BIT_XTEN]})
      3'b010:  mode = rcsc_pkg::RCSC_HIGH_SINGLE;
      3'b011:  mode = rcsc_pkg::RCSC_HIGH_DUAL;
      3'b111:  mode = rcsc_pkg::RCSC_LOW_DUAL;
      3'b101:  mode = rcsc_pkg::RCSC_LOW_SINGLE;
      default: mode = rcsc_pkg::RCSC_HIGH_SINGLE;
    endcase
  end

  // Trap control, timer and fetch monitor
  always_ff @(posedge aclk) begin
    if (!aresetn || int_rst) begin
      wdctl1     <= rcsc_pkg::WDCTL1_RESET;
      tmr_ctl    <= 8'h00;
      tmr_reload <= 16'h0000;
      fetch_addr <= 16'h0000;
    end else begin
      fetch_addr <= 16'h0000;
      if (wr_go) begin
        case (aw_a)
          rcsc_pkg::ADDR_WDCTL1:  wdctl1     <= wr_val;
          rcsc_pkg::ADDR_TMR_CTL: tmr_ctl    <= wr_val;
          rcsc_pkg::ADDR_TMR_CNT: tmr_reload <= w_d[15:0];
          rcsc_pkg::ADDR_FETCH:   fetch_addr <= w_d[15:0];
          default: ;
        endcase
      end
    end
  end

  // Cascaded warm-up counter
  always_ff @(posedge aclk) begin
    if (!aresetn || int_rst || !tmr_ctl[rcsc_pkg::BIT_TMR_RUN]) begin
      tmr_cnt <= 16'h0000;
      tmr_tc  <= 1'b0;
    end else begin
      tmr_tc <= 1'b0;
      if (tmr_cnt == tmr_reload) begin
        tmr_cnt <= 16'h0000;
        tmr_tc  <= (tmr_ctl[2:0] == rcsc_pkg::TMR_CTL_WARMUP[2:0]);
      end else begin
        tmr_cnt <= tmr_cnt + 16'h0001;
      end
    end
  end

  // Interrupt master and enable flags, prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn || int_rst) begin
      irq_master  <= 1'b0;
      irq_enables <= 8'h00;
      prescale    <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
      if (wr_go && aw_a == rcsc_pkg::ADDR_IRQ_EN) begin
        irq_master  <= w_d[8];
        irq_enables <= wr_val;
      end
    end
  end

  // Sticky events: warm-up, trap interrupt, clock fault, watchdog
  assign ev = {watchdog_reset_req, sysclk_fault,
               trap_hit && !wdctl1[rcsc_pkg::BIT_ATOUT], tmr_tc};

  wire rd_st = s_arvalid && s_arready && s_araddr == rcsc_pkg::ADDR_IRQ_ST;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st   <= '0;
      irq_mask <= '0;
    end else begin
      irq_st <= (rd_st ? '0 : irq_st) | ev;
      if (wr_go && aw_a == rcsc_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= wr_val[IRQ_W_L-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st & irq_mask);
    end
  end

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= 2'b00;
    end else if (s_arvalid && s_arready) begin
      s_rvalid  <= 1'b1;
      s_arready <= 1'b0;
      s_rresp  <= 2'b00;
      case (s_araddr)
        rcsc_pkg::ADDR_SYSCTL2:  s_rdata <= {24'h00_0000, sysctl2};
        rcsc_pkg::ADDR_WDCTL1:   s_rdata <= {24'h00_0000, wdctl1};
        rcsc_pkg::ADDR_TMR_CTL:  s_rdata <= {24'h00_0000, tmr_ctl};
        rcsc_pkg::ADDR_TMR_CNT:  s_rdata <= {16'h0000, tmr_cnt};
        rcsc_pkg::ADDR_FETCH:    s_rdata <= 32'h0000_0000;
        rcsc_pkg::ADDR_STATUS:   s_rdata <= {28'h000_0000, sel_low, mode, ext_rst};
        rcsc_pkg::ADDR_IRQ_ST:   s_rdata <= {28'h000_0000, irq_st};
        rcsc_pkg::ADDR_IRQ_MASK: s_rdata <= {28'h000_0000, irq_mask};
        rcsc_pkg::ADDR_IRQ_EN:   s_rdata <= {23'h00_0000, irq_master, irq_enables};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= 2'b10;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end
endmodule

// *** inc/rcsc_pkg.sv ***
// How it works
// - Warm-up counter runs cascaded; terminal count raises interrupt; software stops it.
// - After select clears, low clock stays until both clocks are synchronized.
// - Reset pin low ends slow mode; release starts in high single mode.
// - Four reset sources; three malfunction resets last at most 24 fc periods.
// - Malfunction reset may pulse up to 24 fc at power-up; tolerated.
// - Any reset clears the interrupt master enable.
// - Any reset clears enable flags and loads program counter from reset vector.
// - Reset clears prescaler and divider, keeps watchdog enabled, keeps other state; here reset also reloads control, trap and timer registers.
// - Pin must be low 12 fc clocks before reset initializes state.
// - Pin high releases reset; start address fetched from top two bytes.
// - Fetch from special area, data buffer, or RAM when selected traps.
// - Trap response selectable reset or interrupt; trapped area selectable.
// - Clearing both oscillator enables in one write causes system-clock reset.
// - Clearing high enable while high clock selected causes system-clock reset.
// - Clearing low enable while low clock selected causes system-clock reset.
package rcsc_pkg;
  localparam logic [7:0]  ADDR_SYSCTL2   = 8'h00;
  localparam logic [7:0]  ADDR_WDCTL1    = 8'h04;
  localparam logic [7:0]  ADDR_TMR_CTL   = 8'h08;
  localparam logic [7:0]  ADDR_TMR_CNT   = 8'h0C;
  localparam logic [7:0]  ADDR_FETCH     = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_ST    = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h1C;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h20;
  localparam int          BIT_XEN        = 7;
  localparam int          BIT_XTEN       = 6;
  localparam int          BIT_SYSCK      = 5;
  localparam int          BIT_TRAP_RAM_AREA_SELECT       = 0;
  localparam int          BIT_ATOUT      = 1;
  localparam int          BIT_TMR_RUN    = 3;
  localparam logic [7:0]  SYSCTL2_RESET  = 8'h80;
  localparam logic [7:0]  WDCTL1_RESET   = 8'h02;
  localparam logic [7:0]  TMR_CTL_WARMUP = 8'h05;
  localparam int          FC_MAX_NS      = 25;
  localparam int          MALF_NS        = 24 * FC_MAX_NS;
  localparam int          CLK_NS         = 25;
  localparam logic [4:0]  MALF_CYC       = 5'(MALF_NS / CLK_NS);
  localparam int          PIN_NS         = 12 * FC_MAX_NS;
  localparam logic [4:0]  PIN_CYC        = 5'((PIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0]  SYNC_CYC       = 3'h4;
  localparam logic [15:0] RESET_VECTOR   = 16'hFFFE;
  localparam logic [15:0] SFR_END        = 16'h003F;
  localparam logic [15:0] RAM_END        = 16'h083F;
  localparam logic [15:0] DBR_START      = 16'h0F80;
  localparam logic [15:0] DBR_END        = 16'h0FFF;
  localparam int          IRQ_W          = 4;
  typedef enum logic [1:0] {
    RCSC_HIGH_SINGLE,
    RCSC_HIGH_DUAL,
    RCSC_LOW_DUAL,
    RCSC_LOW_SINGLE
  } rcsc_mode_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } rcsc_fetch_t;
endpackage

// *** verif/rcsc_chk_sva.sv ***
`timescale 1ns/10ps
module rcsc_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Reset sources
  input wire logic        reset_pin_n,
  input wire logic        watchdog_reset_req,
  // Register writes
  input wire logic [7:0]  s_awaddr,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  // System outputs
  input wire logic        sys_reset_n,
  input wire logic        clk_sel_low,
  input wire logic        hf_osc_en,
  input wire logic [15:0] pc_load
);
  logic [4:0] low_cnt;
  wire logic  sys_wr = s_awvalid && s_awready && s_wvalid && s_wready && s_awaddr == rcsc_pkg::ADDR_SYSCTL2;
  // Consecutive low samples of the pin
  always_ff @(posedge aclk) begin
    if (!aresetn || reset_pin_n) low_cnt <= 5'h00;
    else if (low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_PC: assert property (pc_load == rcsc_pkg::RESET_VECTOR)
    else $error("reset vector wrong");
  AST_PIN_RST: assert property (low_cnt == 5'h12 |-> !sys_reset_n)
    else $error("long pin low gave no reset");
  AST_PIN_REL: assert property ($rose(reset_pin_n) |-> ##[1:8] sys_reset_n)
    else $error("pin release did not end reset");
  AST_MODE_REL: assert property ($rose(sys_reset_n) |-> hf_osc_en && !clk_sel_low)
    else $error("reset did not leave high clock mode");
  AST_WD_ON: assert property ($rose(watchdog_reset_req) |-> ##[1:3] !sys_reset_n)
    else $error("watchdog gave no reset");
  AST_WD_LEN: assert property ($fell(watchdog_reset_req) |-> ##2 (!sys_reset_n)[*6] ##[1:20] sys_reset_n)
    else $error("malfunction reset length wrong");
  AST_BOTH_OFF: assert property (sys_wr && s_wdata[7:6] == 2'h0 |-> ##[1:4] !sys_reset_n)
    else $error("both oscillators off gave no reset");
  AST_HF_OFF: assert property (sys_wr && !s_wdata[7] && !s_wdata[5] && !clk_sel_low |-> ##[1:4] !sys_reset_n)
    else $error("high oscillator off gave no reset");
  AST_LF_OFF: assert property (sys_wr && !s_wdata[6] && s_wdata[5] && clk_sel_low |-> ##[1:4] !sys_reset_n)
    else $error("low oscillator off gave no reset");
  AST_SYNC: assert property (sys_wr && s_wdata[7:5] == 3'h6 && clk_sel_low |=> clk_sel_low[*3] ##[1:6] !clk_sel_low)
    else $error("clock switch timing wrong");
  AST_BHOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
endmodule
bind rcsc_top rcsc_chk rcsc_chk_inst (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
  .watchdog_reset_req(watchdog_reset_req), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wdata(s_wdata), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .sys_reset_n(sys_reset_n), .clk_sel_low(clk_sel_low), .hf_osc_en(hf_osc_en), .pc_load(pc_load));

// *** verif/rcsc_pin_model.sv ***
`timescale 1ns/10ps
module rcsc_pin_model (
  // Clock
  input wire logic       aclk,
  // Pulse request
  input wire logic       go,
  input wire logic [5:0] len,
  // Pin
  output logic           reset_pin_n
);
  logic [5:0] cnt = 6'h00;
  always @(posedge aclk) begin
    if (go) cnt <= len;
    else if (cnt != 6'h00) cnt <= cnt - 6'h01;
  end
  // Pulled up unless held low
  assign reset_pin_n = (cnt == 6'h00);
endmodule

// *** verif/rcsc_top_tb.sv ***
`timescale 1ns/10ps
module rcsc_top_tb;
  localparam logic [7:0] A_SYS = rcsc_pkg::ADDR_SYSCTL2;
  localparam logic [7:0] A_WDC = rcsc_pkg::ADDR_WDCTL1;
  localparam logic [7:0] A_FET = rcsc_pkg::ADDR_FETCH;
  localparam logic [7:0] A_IST = rcsc_pkg::ADDR_IRQ_ST;
  localparam logic [7:0] A_MSK = rcsc_pkg::ADDR_IRQ_MASK;
  logic        aclk = 1'h0, aresetn = 1'h0, watchdog_reset_req = 1'h0, pin_go = 1'h0;
  logic [5:0]  pin_len = 6'h00;
  logic        late_b = 1'h0;
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000, s_rdata, rd;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, reset_pin_n;
  logic        sys_reset_n, clk_sel_low, hf_osc_en, lf_osc_en, irq;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [15:0] pc_load;
  logic [7:0]  tw [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
  logic [15:0] ta [4] = '{16'h0010, 16'h0100, 16'h0100, 16'h0f80};
  logic [3:0]  te [4] = '{4'h2, 4'h0, 4'h2, 4'h2};
  logic [7:0]  fd [3] = '{8'h40, 8'h00, 8'ha0};
  int          n_fail = 0, n_tests = 0;
  rcsc_pin_model rcsc_pin_model_inst (.aclk(aclk), .go(pin_go), .len(pin_len), .reset_pin_n(reset_pin_n));
  rcsc_top rcsc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n), .watchdog_reset_req(watchdog_reset_req),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .sys_reset_n(sys_reset_n), .clk_sel_low(clk_sel_low), .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
    .pc_load(pc_load), .irq(irq)
  );
  always #12.5 aclk = ~aclk;
  task automatic give_verdict();
    $display("n_tests %0d n_fail %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= !late_b;
    do begin
      @(posedge aclk);
      k++;
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
      if (s_bvalid === 1'h1 && s_bready !== 1'h1) s_bready <= 1'h1;
    end while (!(s_bvalid === 1'h1 && s_bready === 1'h1) && k < 200);
    if (k >= 200) n_fail++;
    rsp = s_bresp;
    s_bready <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    int k;
    k = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      @(posedge aclk);
      k++;
      if (s_arready) s_arvalid <= 1'h0;
    end while (s_rvalid !== 1'h1 && k < 200);
    if (k >= 200) n_fail++;
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'h0;
    chk_word(rd, exp);
  endtask
  task automatic wait_rst();
    int k;
    k = 0;
    while (sys_reset_n !== 1'h0 && k < 40) begin
      @(posedge aclk);
      k++;
    end
    chk_bit(sys_reset_n, 1'h0);
    while (sys_reset_n !== 1'h1 && k < 120) begin
      @(posedge aclk);
      k++;
    end
    chk_bit(sys_reset_n, 1'h1);
  endtask
  initial begin
    #(25 * 20000);
    n_fail++;
    give_verdict();
  end
  initial begin
    int k;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(A_SYS, 32'h0000_0080);
    rd_chk(A_WDC, 32'h0000_0002);
    rd_chk(rcsc_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    chk_word({16'h0000, pc_load}, 32'h0000_fffe);
    chk_bit(lf_osc_en, 1'h0);
    rd_chk(8'h40, 32'h0000_0000);
    chk_word({30'h0000_0000, rsp}, 32'h0000_0002);
    late_b = 1'h1;
    axi_wr(8'h44, 32'h0000_0001);
    late_b = 1'h0;
    chk_word({30'h0000_0000, rsp}, 32'h0000_0002);
    $display("test regs done");
    axi_wr(A_SYS, 32'h0000_00c0);
    axi_wr(A_SYS, 32'h0000_00e0);
    cyc(12);
    chk_bit(clk_sel_low, 1'h1);
    axi_wr(A_SYS, 32'h0000_0060);
    cyc(4);
    chk_bit(hf_osc_en, 1'h0);
    chk_bit(sys_reset_n, 1'h1);
    chk_bit(lf_osc_en, 1'h1);
    rd_chk(rcsc_pkg::ADDR_STATUS, 32'h0000_000e);
    axi_wr(A_SYS, 32'h0000_00e0);
    axi_wr(A_MSK, 32'h0000_0001);
    axi_wr(rcsc_pkg::ADDR_TMR_CNT, 32'h0000_0020);
    axi_wr(rcsc_pkg::ADDR_TMR_CTL, 32'h0000_000d);
    k = 0;
    while (irq !== 1'h1 && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    chk_bit(irq, 1'h1);
    axi_wr(rcsc_pkg::ADDR_TMR_CTL, 32'h0000_0005);
    rd_chk(A_IST, 32'h0000_0001);
    rd_chk(A_IST, 32'h0000_0000);
    axi_wr(A_SYS, 32'h0000_00c0);
    chk_bit(clk_sel_low, 1'h1);
    cyc(12);
    chk_bit(clk_sel_low, 1'h0);
    $display("test modes done");
    axi_wr(A_MSK, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      axi_wr(A_WDC, {24'h00_0000, tw[i]});
      axi_wr(A_FET, {16'h0000, ta[i]});
      chk_bit(irq, 1'h0);
      rd_chk(A_IST, {28'h000_0000, te[i]});
    end
    axi_wr(A_FET, 32'h0000_003f);
    axi_wr(A_MSK, 32'h0000_0002);
    cyc(2);
    chk_bit(irq, 1'h1);
    rd_chk(A_IST, 32'h0000_0002);
    cyc(2);
    chk_bit(irq, 1'h0);
    axi_wr(rcsc_pkg::ADDR_IRQ_EN, 32'h0000_01ff);
    axi_wr(A_WDC, 32'h0000_0002);
    axi_wr(A_FET, 32'h0000_0fff);
    wait_rst();
    rd_chk(rcsc_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    rd_chk(A_SYS, 32'h0000_0080);
    $display("test trap done");
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        axi_wr(A_SYS, 32'h0000_00c0);
        axi_wr(A_SYS, 32'h0000_00e0);
        cyc(12);
      end
      axi_wr(A_SYS, {24'h00_0000, fd[i]});
      wait_rst();
    end
    @(posedge aclk);
    watchdog_reset_req <= 1'h1;
    @(posedge aclk);
    watchdog_reset_req <= 1'h0;
    wait_rst();
    $display("test faults done");
    axi_wr(A_SYS, 32'h0000_00c0);
    axi_wr(A_SYS, 32'h0000_00e0);
    cyc(12);
    @(posedge aclk);
    pin_len <= 6'h14;
    pin_go <= 1'h1;
    @(posedge aclk);
    pin_go <= 1'h0;
    wait_rst();
    chk_bit(clk_sel_low, 1'h0);
    rd_chk(A_SYS, 32'h0000_0080);
    $display("test pin done");
    give_verdict();
  end
endmodule
